/* File: hdl/t2art_defines.vh */
`ifndef T2ART_DEFINES_VH
`define T2ART_DEFINES_VH

// ==========================================================================
// Register addresses on the 8-bit register port.
// ==========================================================================
`define T2ART_ADDR_CLOCK_SELECT 8'h8e
`define T2ART_ADDR_CONTROL 8'hc8
`define T2ART_ADDR_RELOAD_LOW 8'hca
`define T2ART_ADDR_RELOAD_HIGH 8'hcb
`define T2ART_ADDR_COUNT_LOW 8'hcc
`define T2ART_ADDR_COUNT_HIGH 8'hcd
`define T2ART_ADDR_IRQ_STATUS 8'hd0
`define T2ART_ADDR_IRQ_MASK 8'hd1
`define T2ART_ADDR_IRQ_ENABLE 8'hd2

// ==========================================================================
// Field positions of the control register.
// ==========================================================================
`define T2ART_CTL_HIGH_OVF 7
`define T2ART_CTL_LOW_OVF 6
`define T2ART_CTL_LOW_IRQ_EN 5
`define T2ART_CTL_CAPTURE_EN 4
`define T2ART_CTL_SPLIT 3
`define T2ART_CTL_RUN 2
`define T2ART_CTL_ALT_CLK 0

// ==========================================================================
// Field positions of the clock select register.
// ==========================================================================
`define T2ART_CKS_HIGH_SEL 5
`define T2ART_CKS_LOW_SEL 4

// ==========================================================================
// Interrupt status and mask bits (same layout).
// ==========================================================================
`define T2ART_IRQ_HIGH 0
`define T2ART_IRQ_LOW 1
`define T2ART_IRQ_CAPTURE 2

// ==========================================================================
// Reset values and divider counts.
// ==========================================================================
`define T2ART_RESET_BYTE 8'h00
`define T2ART_RESET_IRQ 3'h0
`define T2ART_SYS_DIVIDE 4'hc
`define T2ART_EXT_DIVIDE 4'h8

`endif

/* File: hdl/t2art_prescale.v */
`timescale 1ns/10ps
`include "t2art_defines.vh"

// ==========================================================================
// System clock divide-by-twelve tick generator.
// ==========================================================================
module t2art_prescale (
  input wire ref_clk_in,
  input wire rst_in,
  input wire ce_in,
  output wire tick_out
);

  // Free running cycle counter, wraps after twelve enabled cycles.
  reg [3:0] div_count;

  // The tick is high on the last cycle of each group of twelve.
  assign tick_out = (div_count == (`T2ART_SYS_DIVIDE - 4'h1));

  // Count enabled system clock cycles.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_count <= 4'h0;
    end else if (ce_in) begin
      if (tick_out) begin
        div_count <= 4'h0;
      end else begin
        div_count <= div_count + 4'h1;
      end
    end
  end

endmodule // t2art_prescale

/* File: hdl/t2art_ext_tick.v */
`timescale 1ns/10ps
`include "t2art_defines.vh"

// ==========================================================================
// External oscillator divide-by-eight, brought into the system clock domain.
// ==========================================================================
module t2art_ext_tick (
  input wire ref_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire ext_osc_in,
  output wire tick_out
);

  // Two-stage synchroniser; only the second stage is looked at.
  reg sync_first;
  reg sync_second;
  // Previous synchronised level, for rising edge detection.
  reg sync_prev;
  // Counts synchronised rising edges of the oscillator.
  reg [2:0] edge_count;

  // Rising edge of the synchronised oscillator.
  wire osc_rise;

  assign osc_rise = sync_second & ~sync_prev;
  // One tick per eight oscillator periods, one system cycle wide.
  assign tick_out = osc_rise & (edge_count == 3'h7);

  // Synchronise, then divide by eight. The oscillator must stay well below
  // half the system clock or edges will be lost in the synchroniser.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      sync_first <= 1'b0;
      sync_second <= 1'b0;
      sync_prev <= 1'b0;
      edge_count <= 3'h0;
    end else if (ce_in) begin
      sync_first <= ext_osc_in;
      sync_second <= sync_first;
      sync_prev <= sync_second;
      if (osc_rise) begin
        edge_count <= edge_count + 3'h1;
      end
    end
  end

endmodule // t2art_ext_tick

/* File: hdl/t2art_timer.v */
// Function
// - Count is low and high byte registers.
// - 16-bit rollover loads reload pair, sets high flag.
// - Split mode: two 8-bit auto-reload counters.
// - Run gates whole timer, or high byte only.
// - Split byte clocks: system clock or alternate.
// - Low select clocks whole timer unless split.
// - Alternate clock: system /12 or external /8.
// - External /8 synchronised before use.
// - Byte rollovers set low and high flags.
// - Interrupt on high flag, low if enabled.
// - Hardware never clears flags; software does.
// - LFO falling edge captures count into reload, with capture and timer interrupt enabled.
// - Control bit 1 reads zero, ignores writes.
// - High reload byte read/write, resets zero.
//
// Strobed register access is this design's own decision.
`timescale 1ns/10ps
`include "t2art_defines.vh"

// ==========================================================================
// Sixteen-bit auto-reload timer with split eight-bit mode.
// ==========================================================================
module t2art_timer (
  input wire ref_clk_in,
  input wire rst_in,
  input wire ce_in,
  input wire [7:0] addr_in,
  input wire [7:0] wr_data_in,
  input wire wr_in,
  input wire rd_in,
  output reg [7:0] rd_data_out,
  input wire ext_osc_in,
  input wire lfo_in,
  output wire irq_out
);

  // ========================================================================
  // Helper functions
  // ========================================================================

  // Picks a byte's tick: system clock when selected, else the alternate.
  function t2art_pick;
    input sys_sel;
    input alt_sel;
    input div_tick;
    input ext_tick;
    begin
      t2art_pick = sys_sel | (alt_sel ? ext_tick : div_tick);
    end
  endfunction

  // ========================================================================
  // Registers
  // ========================================================================

  // Count bytes and their reload bytes.
  reg [7:0] count_low_byte;
  reg [7:0] count_high_byte;
  reg [7:0] reload_low_byte;
  reg [7:0] reload_high_byte;
  // Control register fields; bit 1 has no storage at all.
  reg high_overflow_flag;
  reg low_overflow_flag;
  reg low_irq_enable;
  reg lfo_capture_enable;
  reg split_select;
  reg run_control;
  reg alt_clock_select;
  // Clock select register fields.
  reg high_byte_clock_select;
  reg low_byte_clock_select;
  // Timer interrupt enable, as seen from the interrupt controller.
  reg timer_irq_enable;
  // Sticky interrupt events and their mask.
  reg [2:0] irq_status;
  reg [2:0] irq_mask;
  // Last sampled low-frequency oscillator level.
  reg lfo_prev;

  // ========================================================================
  // Clock sources
  // ========================================================================

  // Divided tick pulses, one system cycle wide.
  wire div12_tick;
  wire ext8_tick;

  // System clock divided by twelve.
  t2art_prescale u_prescale (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .tick_out(div12_tick)
  );

  // External oscillator divided by eight, synchronised first.
  t2art_ext_tick u_ext_tick (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .ext_osc_in(ext_osc_in),
    .tick_out(ext8_tick)
  );

  // Selected ticks for each byte.
  wire low_tick;
  wire high_tick;

  // The low select clocks the whole timer, or the low byte in split mode; the high one only in split mode.
  assign low_tick = t2art_pick(low_byte_clock_select, alt_clock_select,
                               div12_tick, ext8_tick);
  assign high_tick = t2art_pick(high_byte_clock_select, alt_clock_select,
                                div12_tick, ext8_tick);

  // ========================================================================
  // Counter next-state logic
  // ========================================================================

  // Next count bytes and rollover events of this cycle.
  reg [7:0] next_low;
  reg [7:0] next_high;
  reg low_rollover;
  reg high_rollover;

  // Compute the counting step; software writes are applied afterwards.
  always @* begin
    next_low = count_low_byte;
    next_high = count_high_byte;
    low_rollover = 1'b0;
    high_rollover = 1'b0;
    if (!split_select) begin
      // Whole timer stops when run is low.
      if (run_control && low_tick) begin
        if ({count_high_byte, count_low_byte} == 16'hffff) begin
          next_low = reload_low_byte;
          next_high = reload_high_byte;
          low_rollover = 1'b1;
          high_rollover = 1'b1;
        end else begin
          {next_high, next_low} = {count_high_byte, count_low_byte} + 16'h0001;
          low_rollover = (count_low_byte == 8'hff);
        end
      end
    end else begin
      // Low byte runs continuously in split mode.
      if (low_tick) begin
        if (count_low_byte == 8'hff) begin
          next_low = reload_low_byte;
          low_rollover = 1'b1;
        end else begin
          next_low = count_low_byte + 8'h01;
        end
      end
      // High byte is gated by run control only.
      if (run_control && high_tick) begin
        if (count_high_byte == 8'hff) begin
          next_high = reload_high_byte;
          high_rollover = 1'b1;
        end else begin
          next_high = count_high_byte + 8'h01;
        end
      end
    end
  end

  // ========================================================================
  // Register access decode
  // ========================================================================

  // Write strobes per register.
  wire wr_control;
  wire wr_clock_select;
  wire wr_reload_low;
  wire wr_reload_high;
  wire wr_count_low;
  wire wr_count_high;
  wire wr_irq_status;
  wire wr_irq_mask;
  wire wr_irq_enable;
  // Capture event: falling LFO edge with capture and interrupts enabled.
  wire capture_event;

  assign wr_control = wr_in && (addr_in == `T2ART_ADDR_CONTROL);
  assign wr_clock_select = wr_in && (addr_in == `T2ART_ADDR_CLOCK_SELECT);
  assign wr_reload_low = wr_in && (addr_in == `T2ART_ADDR_RELOAD_LOW);
  assign wr_reload_high = wr_in && (addr_in == `T2ART_ADDR_RELOAD_HIGH);
  assign wr_count_low = wr_in && (addr_in == `T2ART_ADDR_COUNT_LOW);
  assign wr_count_high = wr_in && (addr_in == `T2ART_ADDR_COUNT_HIGH);
  assign wr_irq_status = wr_in && (addr_in == `T2ART_ADDR_IRQ_STATUS);
  assign wr_irq_mask = wr_in && (addr_in == `T2ART_ADDR_IRQ_MASK);
  assign wr_irq_enable = wr_in && (addr_in == `T2ART_ADDR_IRQ_ENABLE);
  assign capture_event = lfo_prev && !lfo_in && lfo_capture_enable
                         && timer_irq_enable;

  // ========================================================================
  // Counter and reload storage
  // ========================================================================

  // A software write beats the counting step, so a loaded value reads back as written.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      count_low_byte <= `T2ART_RESET_BYTE;
      count_high_byte <= `T2ART_RESET_BYTE;
    end else if (ce_in) begin
      if (wr_count_low) begin
        count_low_byte <= wr_data_in;
      end else begin
        count_low_byte <= next_low;
      end
      if (wr_count_high) begin
        count_high_byte <= wr_data_in;
      end else begin
        count_high_byte <= next_high;
      end
    end
  end

  // Reload bytes: a capture beats a software write in the same cycle, since
  // the captured count is a hardware event that would otherwise be lost.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      reload_low_byte <= `T2ART_RESET_BYTE;
      reload_high_byte <= `T2ART_RESET_BYTE;
      lfo_prev <= 1'b0;
    end else if (ce_in) begin
      lfo_prev <= lfo_in;
      if (capture_event) begin
        reload_low_byte <= count_low_byte;
        reload_high_byte <= count_high_byte;
      end else begin
        if (wr_reload_low) begin
          reload_low_byte <= wr_data_in;
        end
        if (wr_reload_high) begin
          reload_high_byte <= wr_data_in;
        end
      end
    end
  end

  // ========================================================================
  // Control, clock select and interrupt registers
  // ========================================================================

  // Overflow flags are set by hardware and cleared only by software; a set
  // in the same cycle as a clearing write wins.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      high_overflow_flag <= 1'b0;
      low_overflow_flag <= 1'b0;
      low_irq_enable <= 1'b0;
      lfo_capture_enable <= 1'b0;
      split_select <= 1'b0;
      run_control <= 1'b0;
      alt_clock_select <= 1'b0;
      high_byte_clock_select <= 1'b0;
      low_byte_clock_select <= 1'b0;
      timer_irq_enable <= 1'b0;
      irq_mask <= `T2ART_RESET_IRQ;
    end else if (ce_in) begin
      if (wr_control) begin
        // Bit 1 is simply not stored.
        low_irq_enable <= wr_data_in[`T2ART_CTL_LOW_IRQ_EN];
        lfo_capture_enable <= wr_data_in[`T2ART_CTL_CAPTURE_EN];
        split_select <= wr_data_in[`T2ART_CTL_SPLIT];
        run_control <= wr_data_in[`T2ART_CTL_RUN];
        alt_clock_select <= wr_data_in[`T2ART_CTL_ALT_CLK];
      end
      high_overflow_flag <= high_rollover
        | (wr_control ? wr_data_in[`T2ART_CTL_HIGH_OVF] : high_overflow_flag);
      low_overflow_flag <= low_rollover
        | (wr_control ? wr_data_in[`T2ART_CTL_LOW_OVF] : low_overflow_flag);
      if (wr_clock_select) begin
        high_byte_clock_select <= wr_data_in[`T2ART_CKS_HIGH_SEL];
        low_byte_clock_select <= wr_data_in[`T2ART_CKS_LOW_SEL];
      end
      if (wr_irq_mask) begin
        irq_mask <= wr_data_in[2:0];
      end
      if (wr_irq_enable) begin
        timer_irq_enable <= wr_data_in[0];
      end
    end
  end

  // Sticky event bits, cleared by writing one; a new event wins the clear.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      irq_status <= `T2ART_RESET_IRQ;
    end else if (ce_in) begin
      irq_status <= (irq_status & ~(wr_irq_status ? wr_data_in[2:0] : 3'h0))
                    | {capture_event, low_rollover, high_rollover};
    end
  end

  // Interrupt request: unmasked high and capture events, unmasked low events only
  // when the low byte interrupt is enabled, all behind the timer interrupt enable.
  assign irq_out = timer_irq_enable
    & ((irq_status[`T2ART_IRQ_HIGH] & irq_mask[`T2ART_IRQ_HIGH])
    | (irq_status[`T2ART_IRQ_LOW] & irq_mask[`T2ART_IRQ_LOW] & low_irq_enable)
    | (irq_status[`T2ART_IRQ_CAPTURE] & irq_mask[`T2ART_IRQ_CAPTURE]));

  // ========================================================================
  // Read port
  // ========================================================================

  // Read data stand for one cycle after the strobe and are zero otherwise;
  // unmapped addresses read zero.
  always @(posedge ref_clk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_out <= 8'h00;
    end else if (ce_in) begin
      rd_data_out <= 8'h00;
      if (rd_in) begin
        case (addr_in)
          `T2ART_ADDR_CONTROL: begin
            rd_data_out <= {high_overflow_flag, low_overflow_flag, low_irq_enable,
                            lfo_capture_enable, split_select, run_control,
                            1'b0, alt_clock_select};
          end
          `T2ART_ADDR_CLOCK_SELECT:
            rd_data_out <= {2'b00, high_byte_clock_select, low_byte_clock_select, 4'h0};
          `T2ART_ADDR_RELOAD_LOW: rd_data_out <= reload_low_byte;
          `T2ART_ADDR_RELOAD_HIGH: rd_data_out <= reload_high_byte;
          `T2ART_ADDR_COUNT_LOW: rd_data_out <= count_low_byte;
          `T2ART_ADDR_COUNT_HIGH: rd_data_out <= count_high_byte;
          `T2ART_ADDR_IRQ_STATUS: rd_data_out <= {5'h00, irq_status};
          `T2ART_ADDR_IRQ_MASK: rd_data_out <= {5'h00, irq_mask};
          `T2ART_ADDR_IRQ_ENABLE: rd_data_out <= {7'h00, timer_irq_enable};
          default: rd_data_out <= 8'h00;
        endcase
      end
    end
  end

endmodule // t2art_timer

/* File: testbench/t2art_checker.sv */
`timescale 1ns/10ps
`include "t2art_defines.vh"

// ==========================================================================
// Port checks: register read path and interrupt line.
// ==========================================================================
module t2art_checker (
  input wire logic ref_clk_in,
  input wire logic rst_in,
  input wire logic ce_in,
  input wire logic [7:0] addr_in,
  input wire logic [7:0] wr_data_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] rd_data_out,
  input wire logic lfo_in,
  input wire logic irq_out
);
  // Everything here lives in the one system clock domain.
  default clocking cb @(posedge ref_clk_in);
  endclocking
  default disable iff (rst_in);

  // A taken write to one address, then at once a taken read of it.
  sequence s_wr_rd(a);
    ce_in && wr_in && addr_in == a ##1 ce_in && rd_in && addr_in == a;
  endsequence

  // No slow-oscillator fall could have overwritten the reload bytes meanwhile.
  sequence s_lfo_quiet;
    !$past(lfo_in) && !$past(lfo_in, 2);
  endsequence

  a_rd_idle_zero: assert property (
    ce_in && !rd_in |=> rd_data_out == 8'h00)
    else $error("read data not zero outside a read");
  a_ctl_bit_one: assert property (
    ce_in && rd_in && addr_in == `T2ART_ADDR_CONTROL |=> !rd_data_out[1])
    else $error("unused control bit read as one");
  a_ctl_readback: assert property (
    s_wr_rd(`T2ART_ADDR_CONTROL) |=> (rd_data_out & 8'h3d) == ($past(wr_data_in, 2) & 8'h3d))
    else $error("control bits not read back as written");
  a_reload_readback: assert property (
    s_wr_rd(`T2ART_ADDR_RELOAD_HIGH) ##0 s_lfo_quiet |=> rd_data_out == $past(wr_data_in, 2))
    else $error("high reload byte not read back");
  a_count_write: assert property (
    s_wr_rd(`T2ART_ADDR_COUNT_LOW) |=> rd_data_out == $past(wr_data_in, 2))
    else $error("count write not visible next cycle");
  a_irq_ie_off: assert property (
    ce_in && wr_in && addr_in == `T2ART_ADDR_IRQ_ENABLE && !wr_data_in[0] |=> !irq_out)
    else $error("interrupt with timer enable off");
  a_irq_mask_off: assert property (
    ce_in && wr_in && addr_in == `T2ART_ADDR_IRQ_MASK && wr_data_in == 8'h00 |=> !irq_out)
    else $error("interrupt with all sources masked");
  a_irq_sticky: assert property (
    irq_out && !wr_in |=> irq_out)
    else $error("interrupt dropped without a software write");
endmodule // t2art_checker

bind t2art_timer t2art_checker u_chk (.ref_clk_in(ref_clk_in), .rst_in(rst_in), .ce_in(ce_in),
  .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in), .rd_in(rd_in),
  .rd_data_out(rd_data_out), .lfo_in(lfo_in), .irq_out(irq_out));

/* File: testbench/tb.sv */
`timescale 1ns/10ps
`include "t2art_defines.vh"

// ==========================================================================
// Self-checking bench for the auto-reload timer.
// ==========================================================================
module tb;
  // Short aliases for the register map.
  localparam [7:0] ad_cks = `T2ART_ADDR_CLOCK_SELECT, ad_ctl = `T2ART_ADDR_CONTROL;
  localparam [7:0] ad_rll = `T2ART_ADDR_RELOAD_LOW, ad_rlh = `T2ART_ADDR_RELOAD_HIGH;
  localparam [7:0] ad_cnl = `T2ART_ADDR_COUNT_LOW, ad_cnh = `T2ART_ADDR_COUNT_HIGH;
  localparam [7:0] ad_st = `T2ART_ADDR_IRQ_STATUS, ad_msk = `T2ART_ADDR_IRQ_MASK;
  localparam [7:0] ad_ie = `T2ART_ADDR_IRQ_ENABLE;
  logic ref_clk_in, rst_in, ce_in, wr_in, rd_in, ext_osc_in, lfo_in;
  logic [7:0] addr_in, wr_data_in, d;
  wire [7:0] rd_data_out;
  wire irq_out;
  int fail_count = 0;
  int tests_run = 0;
  int cycles = 0;

  t2art_timer u_dut (
    .ref_clk_in(ref_clk_in),
    .rst_in(rst_in),
    .ce_in(ce_in),
    .addr_in(addr_in),
    .wr_data_in(wr_data_in),
    .wr_in(wr_in),
    .rd_in(rd_in),
    .rd_data_out(rd_data_out),
    .ext_osc_in(ext_osc_in),
    .lfo_in(lfo_in),
    .irq_out(irq_out)
  );

  // ==========================================================================
  // Clock, hang guard and helpers.
  // ==========================================================================
  initial begin
    ref_clk_in = 1'b0;
    forever #25 ref_clk_in = ~ref_clk_in;
  end

  // The tests take under a thousand cycles, so this only trips on a hang.
  always @(posedge ref_clk_in) begin
    cycles++;
    if (cycles == 3000) begin
      fail_count++;
      summarize();
    end
  end

  // Compares one byte and counts it.
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    tests_run++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Looks at the interrupt line once the edge's updates have landed.
  task automatic chki(input logic e);
    #1 chk({7'h00, irq_out}, {7'h00, e});
  endtask

  // One-cycle register write.
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= v;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask

  // One-cycle read; the data stand only in the following cycle.
  task automatic rd(input logic [7:0] a, output logic [7:0] v);
    @(posedge ref_clk_in);
    rd_in <= 1'b1;
    addr_in <= a;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 v = rd_data_out;
  endtask

  // Read and compare.
  task automatic rc(input logic [7:0] a, input logic [7:0] e);
    logic [7:0] v;
    rd(a, v);
    chk(v, e);
  endtask

  // Write immediately followed by a read of the same place.
  task automatic wrc(input logic [7:0] a, input logic [7:0] v, input logic [7:0] e);
    @(posedge ref_clk_in);
    wr_in <= 1'b1;
    addr_in <= a;
    wr_data_in <= v;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    #1 chk(rd_data_out, e);
  endtask

  // ==========================================================================
  // Scenarios.
  // ==========================================================================
  // Every register, plus two unmapped places, reads zero after reset.
  task automatic t_reset;
    logic [7:0] m [11] = '{ad_cks, ad_ctl, ad_rll, ad_rlh, ad_cnl, ad_cnh, ad_st, ad_msk,
      ad_ie, 8'hc9, 8'hff};
    foreach (m[i]) rc(m[i], 8'h00);
    chki(1'b0);
    $display("reset test done");
  endtask

  // Control bits read back, bit one never sticks; reload bytes are read/write.
  task automatic t_regs;
    wrc(ad_ctl, 8'h3f, 8'h3d);
    wrc(ad_ctl, 8'hc2, 8'hc0);
    wr(ad_ctl, 8'h00);
    wrc(ad_rlh, 8'ha5, 8'ha5);
    wrc(ad_rll, 8'h5a, 8'h5a);
    $display("register test done");
  endtask

  // Rollover lands on the same edge as the stop write: flags must still set.
  task automatic t_roll;
    wr(ad_cks, 8'h10);
    wr(ad_rll, 8'h34);
    wr(ad_rlh, 8'h12);
    wr(ad_cnl, 8'hfe);
    wr(ad_cnh, 8'hff);
    wr(ad_ctl, 8'h04);
    wr(ad_ctl, 8'h00);
    rc(ad_cnl, 8'h34);
    rc(ad_cnh, 8'h12);
    rc(ad_ctl, 8'hc0);
    rc(ad_st, 8'h03);
    wr(ad_msk, 8'h01);
    chki(1'b0);
    wr(ad_ie, 8'h01);
    chki(1'b1);
    wr(ad_msk, 8'h02);
    chki(1'b0);
    wr(ad_ctl, 8'he0);
    chki(1'b1);
    repeat (20) @(posedge ref_clk_in);
    rc(ad_ctl, 8'he0);
    chki(1'b1);
    wr(ad_st, 8'h03);
    chki(1'b0);
    wr(ad_msk, 8'h00);
    wr(ad_ie, 8'h00);
    wr(ad_ctl, 8'h00);
    $display("rollover test done");
  endtask

  // Split mode: low byte runs with run off, high byte only when run is on.
  task automatic t_split;
    wr(ad_rll, 8'h80);
    wr(ad_cnh, 8'h55);
    wr(ad_cnl, 8'hff);
    wr(ad_ctl, 8'h08);
    rc(ad_cnl, 8'h80);
    rc(ad_cnh, 8'h55);
    rc(ad_ctl, 8'h48);
    wr(ad_cks, 8'h30);
    wr(ad_rlh, 8'h77);
    wr(ad_cnh, 8'hfe);
    wr(ad_ctl, 8'h0c);
    wr(ad_ctl, 8'h08);
    rc(ad_cnh, 8'h77);
    rd(ad_ctl, d);
    chk(d & 8'h88, 8'h88);
    wr(ad_ctl, 8'h00);
    wr(ad_cks, 8'h20);
    wr(ad_cnl, 8'h00);
    wr(ad_ctl, 8'h04);
    wr(ad_ctl, 8'h00);
    rd(ad_cnl, d);
    chk(d & 8'hfe, 8'h00);
    $display("split test done");
  endtask

  // Divide-by-twelve over 122 run edges, then sixteen external edges.
  task automatic t_alt;
    wr(ad_cks, 8'h00);
    wr(ad_cnl, 8'h00);
    wr(ad_ctl, 8'h04);
    repeat (120) @(posedge ref_clk_in);
    wr(ad_ctl, 8'h00);
    rd(ad_cnl, d);
    chk(d >> 1, 8'h05);
    wr(ad_cnl, 8'h00);
    wr(ad_ctl, 8'h05);
    repeat (16) begin
      repeat (3) @(posedge ref_clk_in);
      ext_osc_in <= 1'b1;
      repeat (4) @(posedge ref_clk_in);
      ext_osc_in <= 1'b0;
    end
    repeat (6) @(posedge ref_clk_in);
    wr(ad_ctl, 8'h00);
    rc(ad_cnl, 8'h02);
    $display("alternate clock test done");
  endtask

  // A slow-oscillator fall copies the count into the reload pair.
  task automatic t_cap;
    wr(ad_st, 8'h07);
    wr(ad_cnl, 8'h3c);
    wr(ad_cnh, 8'hc3);
    // With the timer interrupt enable off, a fall must leave the reload alone.
    wr(ad_ctl, 8'h10);
    @(posedge ref_clk_in);
    lfo_in <= 1'b1;
    @(posedge ref_clk_in);
    lfo_in <= 1'b0;
    rc(ad_rll, 8'h80);
    rc(ad_st, 8'h00);
    wr(ad_ie, 8'h01);
    wr(ad_msk, 8'h04);
    wr(ad_ctl, 8'h10);
    @(posedge ref_clk_in);
    lfo_in <= 1'b1;
    @(posedge ref_clk_in);
    lfo_in <= 1'b0;
    @(posedge ref_clk_in);
    rc(ad_rll, 8'h3c);
    rc(ad_rlh, 8'hc3);
    rc(ad_st, 8'h04);
    chki(1'b1);
    wr(ad_st, 8'h04);
    chki(1'b0);
    wr(ad_ctl, 8'h00);
    $display("capture test done");
  endtask

  // Clock enable low freezes counting; count writes apply on the next cycle.
  task automatic t_ce;
    wr(ad_cks, 8'h10);
    wr(ad_cnl, 8'h00);
    wr(ad_ctl, 8'h04);
    @(posedge ref_clk_in);
    ce_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    ce_in <= 1'b1;
    wr(ad_ctl, 8'h00);
    rc(ad_cnl, 8'h03);
    wrc(ad_cnl, 8'h99, 8'h99);
    $display("clock enable test done");
  endtask

  // Prints the counts and the verdict, then ends the run.
  task automatic summarize;
    $display("checks=%0d mismatches=%0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence: twelve cycles of reset, then each scenario in turn.
  initial begin
    rst_in = 1'b1;
    ce_in = 1'b1;
    wr_in = 1'b0;
    rd_in = 1'b0;
    ext_osc_in = 1'b0;
    lfo_in = 1'b0;
    addr_in = 8'h00;
    wr_data_in = 8'h00;
    repeat (12) @(posedge ref_clk_in);
    rst_in <= 1'b0;
    t_reset();
    t_regs();
    t_roll();
    t_split();
    t_alt();
    t_cap();
    t_ce();
    summarize();
  end
endmodule // tb
